// [rtl/dcr_bank.sv]
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
// Holds the two converter words, relays the newest waiting write serially to the converter,
// and sequences the logic-image load from the boot jumper.
module dcr_bank (
   input wire logic clock,
   input wire logic nrst,
   input wire dcr_pkg::dcr_bus_t bus,
   output logic [31:0] rdata,
   input wire logic bootLoadJumper,
   input wire logic pllLockPin,
   input wire logic loadDonePin,
   output logic loadRequest,
   output logic serClk,
   output logic serCsN,
   output logic serData,
   output logic converterReset,
   output dcr_pkg::dcr_mode_t modeOut,
   output dcr_pkg::dcr_pll_t pllOut,
   output logic busy
);
   typedef enum logic [2:0] {
      LD_IDLE = 3'b001,
      LD_PULSE = 3'b010,
      LD_WAIT = 3'b100
   } dcr_load_t;
   dcr_load_t loadState;
   logic [27:0] modeReg;
   logic [27:0] pllReg;
   logic [2:0] lockSync;
   logic [2:0] jumpSync;
   logic [2:0] doneSync;
   logic lockStable;
   logic jumpStable;
   logic doneStable;
   logic [31:0] shiftReg;
   logic [5:0] bitCount;
   logic [1:0] divCount;
   logic sclkTick;
   logic [31:0] pendWord;
   logic pending;
   logic [15:0] loadCount;
   logic wrMode;
   logic wrPll;

   // Three-stage synchronisers; a change counts when stages two and three agree
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         lockSync <= 3'b000;
         jumpSync <= 3'b000;
         doneSync <= 3'b000;
      end else begin
         lockSync <= {lockSync[1:0], pllLockPin};
         jumpSync <= {jumpSync[1:0], bootLoadJumper};
         doneSync <= {doneSync[1:0], loadDonePin};
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         lockStable <= 1'b0;
         jumpStable <= 1'b0;
         doneStable <= 1'b0;
      end else begin
         if (lockSync[1] == lockSync[2]) lockStable <= lockSync[2];
         if (jumpSync[1] == jumpSync[2]) jumpStable <= jumpSync[2];
         if (doneSync[1] == doneSync[2]) doneStable <= doneSync[2];
      end
   end

   // Address picks the target word; top nibble of the write data must agree
   assign wrMode = bus.wr && bus.addr == dcr_pkg::ADDR_MODE
                   && bus.wdata[31:28] == dcr_pkg::SEL_MODE;
   assign wrPll = bus.wr && bus.addr == dcr_pkg::ADDR_PLL
                  && bus.wdata[31:28] == dcr_pkg::SEL_PLL;

   // Masks drop the read-only lock bit and unused positions except mode bits 23, 22, 18, 9 and 5
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         modeReg <= dcr_pkg::MODE_RESET;
      end else if (wrMode) begin
         modeReg <= bus.wdata[27:0] & dcr_pkg::MODE_MASK;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pllReg <= dcr_pkg::PLL_RESET;
      end else if (wrPll) begin
         pllReg <= bus.wdata[27:0] & dcr_pkg::PLL_MASK;
      end
   end

   // Decoded fields to converter-side controls
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         modeOut <= '0;
         pllOut <= '0;
      end else begin
         modeOut.sleep <= modeReg[20];
         modeOut.powerDown <= modeReg[19];
         modeOut.interpRate <= modeReg[15:14];
         modeOut.modulation <= modeReg[13:12];
         modeOut.zeroStuff <= modeReg[11];
         modeOut.realMix <= modeReg[10];
         modeOut.pinSelClock <= modeReg[8];
         modeOut.unsignedData <= modeReg[7];
         modeOut.onePort <= modeReg[6];
         modeOut.invDataStrobe <= modeReg[4];
         modeOut.invSinglePort <= modeReg[2];
         modeOut.invChanSel <= modeReg[1];
         modeOut.qFirst <= modeReg[0];
         pllOut.prescale <= pllReg[17:16];
         pllOut.pllOn <= pllReg[15];
         pllOut.pumpProgrammed <= pllReg[14];
         pllOut.pumpValue <= pllReg[10:8];
         pllOut.fineGain <= pllReg[7:0];
      end
   end

   // Software reset is a pulse, not a stored level
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         converterReset <= 1'b0;
      end else begin
         converterReset <= wrMode && bus.wdata[dcr_pkg::MODE_SWRESET_BIT];
      end
   end

   // Read data one cycle after the strobe; lock bit is live
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata <= 32'h0000_0000;
      end else if (bus.rd) begin
         case (bus.addr)
            dcr_pkg::ADDR_MODE: rdata <= {dcr_pkg::SEL_MODE,
               modeReg | (28'(lockStable) << dcr_pkg::MODE_LOCK_BIT)};
            dcr_pkg::ADDR_PLL: rdata <= {dcr_pkg::SEL_PLL, pllReg};
            dcr_pkg::ADDR_STATUS: rdata <= {28'h0000000, jumpStable,
               loadState == LD_IDLE, pending, busy};
            default: rdata <= 32'h0000_0000;
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   // Serial clock enable from a divider
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         divCount <= 2'h0;
      end else begin
         divCount <= divCount + 2'h1;
      end
   end
   assign sclkTick = (divCount == 2'(dcr_pkg::SCLK_DIV - 1));

   // One-word holding slot; a write during a transfer waits, a later one replaces it
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pending <= 1'b0;
         pendWord <= 32'h0000_0000;
      end else if (wrMode || wrPll) begin
         pending <= 1'b1;
         pendWord <= bus.wdata & {4'hF, wrMode ? dcr_pkg::MODE_MASK : dcr_pkg::PLL_MASK};
      end else if (pending && !busy && sclkTick) begin
         pending <= 1'b0;
      end
   end

   // Serial relay, most significant bit first, one bit per two ticks
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         busy <= 1'b0;
         serCsN <= 1'b1;
         serClk <= 1'b0;
         serData <= 1'b0;
         shiftReg <= 32'h0000_0000;
         bitCount <= 6'h00;
      end else if (sclkTick) begin
         if (!busy) begin
            if (pending && !(wrMode || wrPll)) begin
               busy <= 1'b1;
               serCsN <= 1'b0;
               serData <= pendWord[31];
               shiftReg <= {pendWord[30:0], 1'b0};
               bitCount <= 6'(dcr_pkg::SHIFT_LEN);
            end
         end else if (!serClk) begin
            serClk <= 1'b1;
         end else begin
            serClk <= 1'b0;
            if (bitCount == 6'h01) begin
               busy <= 1'b0;
               serCsN <= 1'b1;
            end else begin
               serData <= shiftReg[31];
               shiftReg <= {shiftReg[30:0], 1'b0};
            end
            bitCount <= bitCount - 6'h01;
         end
      end
   end

   // Image load after reset only when jumper fitted
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         loadState <= LD_PULSE;
         loadRequest <= 1'b0;
         loadCount <= 16'h0000;
      end else begin
         case (loadState)
            LD_PULSE: begin
               if (loadCount < 16'(dcr_pkg::LOAD_CYCLES)) begin
                  loadCount <= loadCount + 16'h0001; // let jumper settle
               end else if (jumpStable) begin
                  loadRequest <= 1'b1;
                  loadState <= LD_WAIT;
               end else begin
                  loadState <= LD_IDLE;
               end
            end
            LD_WAIT: begin
               if (doneStable) begin
                  loadRequest <= 1'b0;
                  loadState <= LD_IDLE;
               end
            end
            LD_IDLE: loadRequest <= 1'b0;
            default: loadState <= LD_IDLE;
         endcase
      end
   end
endmodule

// [rtl/dcr_pkg.sv]
// What this block does
// - Jumper fitted: load logic image at power-up/reset
// - Jumper absent: no automatic load, await JTAG
// - Top nibble selects register: 0 mode, 1 PLL
// - Mode bit 21 issues converter software reset
// - Mode bit 20 puts converter to sleep
// - Mode bit 19 powers converter fully down
// - Mode bit 17 reads PLL lock, writes ignored
// - Mode bits 15:14 pick interpolation rate
// - Mode bits 13:12 pick modulation mode
// - Mode bit 11 enables zero stuffing
// - Mode bit 10: complex or real mixing
// - Mode bit 8: shared pin lock or clock
// - Mode bit 7: signed or unsigned samples
// - Mode bit 6: two-port or one-port input
// - Mode bits 4,2,1 invert three strobes
// - Mode bit 0: I or Q first
// - PLL bit 15 enable, bits 17:16 prescaler
// - PLL bit 14 charge-pump mode, bits 10:8 value
// - PLL bits 7:0 in-phase fine gain
package dcr_pkg;
   localparam logic [3:0] SEL_MODE = 4'h0;
   localparam logic [3:0] SEL_PLL = 4'h1;
   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_PLL = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   localparam int SEL_LSB = 28;
   // Writable masks; read-only positions stay zero, unused ones too except mode bits 23, 22, 18, 9 and 5
   localparam logic [27:0] MODE_MASK = 28'h0DCFFF7;
   localparam logic [27:0] PLL_MASK = 28'h003C7FF;
   localparam logic [27:0] MODE_RESET = 28'h0000000;
   localparam logic [27:0] PLL_RESET = 28'h0000000;
   localparam int MODE_SWRESET_BIT = 21;
   localparam int MODE_LOCK_BIT = 17;
   localparam int SHIFT_LEN = 32;
   localparam int SCLK_DIV = 4;
   localparam int LOAD_TIME_NS = 2000;
   localparam int CLK_NS = 10;
   localparam int LOAD_CYCLES = (LOAD_TIME_NS + CLK_NS - 1) / CLK_NS;
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } dcr_bus_t;
   typedef struct packed {
      logic sleep;
      logic powerDown;
      logic [1:0] interpRate;
      logic [1:0] modulation;
      logic zeroStuff;
      logic realMix;
      logic pinSelClock;
      logic unsignedData;
      logic onePort;
      logic invDataStrobe;
      logic invSinglePort;
      logic invChanSel;
      logic qFirst;
   } dcr_mode_t;
   typedef struct packed {
      logic [1:0] prescale;
      logic pllOn;
      logic pumpProgrammed;
      logic [2:0] pumpValue;
      logic [7:0] fineGain;
   } dcr_pll_t;
endpackage

// [verif/dcr_bank_monitor.sv]
`timescale 1ns/1ps
module dcr_bank_monitor (
   input wire logic clock,
   input wire logic nrst,
   input wire dcr_pkg::dcr_bus_t bus,
   input wire logic [31:0] rdata,
   input wire logic bootLoadJumper,
   input wire logic loadRequest,
   input wire logic converterReset,
   input wire dcr_pkg::dcr_mode_t modeOut,
   input wire dcr_pkg::dcr_pll_t pllOut
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // Writes accepted only with matching address and selector nibble
   sequence modeWr;
      bus.wr && bus.addr == dcr_pkg::ADDR_MODE && bus.wdata[31:28] == dcr_pkg::SEL_MODE;
   endsequence
   sequence pllWr;
      bus.wr && bus.addr == dcr_pkg::ADDR_PLL && bus.wdata[31:28] == dcr_pkg::SEL_PLL;
   endsequence
   rd_idle_a: assert property (!$past(bus.rd) |-> rdata == 32'h0)
      else $error("read data not idle");
   swreset_fire_a: assert property (modeWr ##0 bus.wdata[21] |=> converterReset)
      else $error("software reset missing");
   swreset_cause_a: assert property (converterReset |-> $past(bus.wr && bus.wdata[21]))
      else $error("stray software reset");
   sleep_power_a: assert property (modeWr |-> ##2
      modeOut.sleep == $past(bus.wdata[20], 2)
      && modeOut.powerDown == $past(bus.wdata[19], 2)) else $error("sleep or power-down wrong");
   rate_mod_a: assert property (modeWr |-> ##2
      {modeOut.interpRate, modeOut.modulation} == $past(bus.wdata[15:12], 2))
      else $error("rate or modulation wrong");
   pll_gain_a: assert property (pllWr |-> ##2
      pllOut.fineGain == $past(bus.wdata[7:0], 2)
      && pllOut.pllOn == $past(bus.wdata[15], 2)) else $error("pll word wrong");
   bad_nibble_a: assert property (bus.wr && bus.addr == dcr_pkg::ADDR_MODE
      && bus.wdata[31:28] != dcr_pkg::SEL_MODE && !$past(bus.wr)
      |-> ##2 modeOut == $past(modeOut, 2)) else $error("foreign word stored");
   load_jumper_a: assert property ($rose(loadRequest) |-> bootLoadJumper)
      else $error("load without jumper");
endmodule
bind dcr_bank dcr_bank_monitor u_mon (.clock(clock), .nrst(nrst), .bus(bus), .rdata(rdata),
   .bootLoadJumper(bootLoadJumper), .loadRequest(loadRequest), .converterReset(converterReset),
   .modeOut(modeOut), .pllOut(pllOut));

// [verif/dcr_conv_model.sv]
`timescale 1ns/1ps
module dcr_conv_model (
   input wire logic clock,
   input wire logic serClk,
   input wire logic serCsN,
   input wire logic serData,
   input wire logic loadRequest,
   output logic loadDonePin = 1'b0,
   output logic [31:0] word = 32'h0,
   output int bits = 0
);
   logic [7:0] cnt = 8'h00;
   // Shift on rising serial clock, selector nibble arrives first
   always @(posedge serClk) begin
      if (!serCsN) begin
         word <= {word[30:0], serData};
         bits <= bits + 1;
      end
   end
   // Image load takes some cycles before done is reported
   always @(posedge clock) begin
      cnt <= loadRequest ? cnt + 8'h01 : 8'h00;
      loadDonePin <= cnt > 8'h0F;
   end
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   dcr_pkg::dcr_bus_t bus = '0;
   logic [31:0] rdata, word, d, v;
   logic jumper = 1'b0;
   logic lock = 1'b0;
   logic sawRst = 1'b0;
   logic done, loadRequest, serClk, serCsN, serData, convRst, busy;
   dcr_pkg::dcr_mode_t modeOut;
   dcr_pkg::dcr_pll_t pllOut;
   int bits, bad_count, cmp_count, cyc;
   logic [27:0] m;
   // Order keeps pll enable in step with the rate; pin bits 23/22 stay zero
   logic [31:0] tbl [6] = '{32'h0000F000, 32'h100285AA, 32'h00020000,
      32'h10014255, 32'h0010A945, 32'h00085492};
   dcr_bank u_dut (.clock(clock), .nrst(nrst), .bus(bus), .rdata(rdata), .bootLoadJumper(jumper),
      .pllLockPin(lock), .loadDonePin(done), .loadRequest(loadRequest), .serClk(serClk),
      .serCsN(serCsN), .serData(serData), .converterReset(convRst), .modeOut(modeOut),
      .pllOut(pllOut), .busy(busy));
   dcr_conv_model u_conv (.clock(clock), .serClk(serClk), .serCsN(serCsN), .serData(serData),
      .loadRequest(loadRequest), .loadDonePin(done), .word(word), .bits(bits));
   // 100 MHz clock
   initial forever #5 clock = ~clock;
   // Cycle ceiling, and a catcher since the reset pulse lasts one cycle
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (convRst === 1'b1) sawRst <= 1'b1;
      if (cyc == 20000) begin
         bad_count++;
         results();
      end
   end
   function automatic dcr_pkg::dcr_mode_t mexp(input logic [31:0] w);
      return {w[20], w[19], w[15:12], w[11:10], w[8:6], w[4], w[2:1], w[0]};
   endfunction
   function automatic dcr_pkg::dcr_pll_t pexp(input logic [31:0] w);
      return {w[17:14], w[10:0]};
   endfunction
   task results;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] w);
      @(posedge clock);
      bus.addr <= a;
      bus.wdata <= w;
      bus.wr <= 1'b1;
      @(posedge clock);
      bus.wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge clock);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clock);
      bus.rd <= 1'b0;
      @(negedge clock);
      d = rdata;
   endtask
   // Serial relay must finish before the next look; bounded wait on busy
   task idle;
      repeat (8) @(posedge clock);
      for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clock);
      repeat (8) @(posedge clock);
   endtask
   initial begin
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      repeat (dcr_pkg::LOAD_CYCLES + 20) @(posedge clock);
      check("load", 32'(loadRequest), 32'h0);
      foreach (tbl[i]) begin
         v = tbl[i];
         wr(v[31:28], v);
         idle();
         if (v[28]) check("pll", 32'(pllOut), 32'(pexp(v)));
         if (!v[28]) check("mode", 32'(modeOut), 32'(mexp(v)));
         if (!v[28]) check("mode", 32'(modeOut), 32'(mexp(v)));
         rd(v[31:28]);
         m = v[28] ? dcr_pkg::PLL_MASK : dcr_pkg::MODE_MASK;
         check("readback", 32'(d[27:0]), 32'(v[27:0] & m));
         check("serial", word, {v[31:28], v[27:0] & m});
      end
      sawRst = 1'b0;
      wr(4'h0, 32'h00200000);
      idle();
      check("swreset", 32'(sawRst), 32'h1);
      rd(4'h0);
      check("bit21", 32'(d[21]), 32'h0);
      lock <= 1'b1;
      wr(4'h0, 32'h00000000);
      idle();
      rd(4'h0);
      check("lock", 32'(d[17]), 32'h1);
      wr(4'h0, 32'h10000001);
      wr(4'h1, 32'h000000FF);
      idle();
      check("mode", 32'(modeOut), 32'h0);
      check("pll", 32'(pllOut), 32'(pexp(32'h10014255)));
      rd(4'hF);
      check("unmapped", d, 32'h0);
      // Second reset with the jumper fitted must request an image load
      @(posedge clock);
      jumper <= 1'b1;
      nrst <= 1'b0;
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      for (int i = 0; i < dcr_pkg::LOAD_CYCLES + 100 && loadRequest !== 1'b1; i++)
         @(posedge clock);
      check("load", 32'(loadRequest), 32'h1);
      for (int i = 0; i < 100 && loadRequest !== 1'b0; i++) @(posedge clock);
      check("load", 32'(loadRequest), 32'h0);
      results();
   end
endmodule
